// ===== include/epc_pkg.sv
// package for the event performance counter block: register numbers,
// field positions, reset values and sizes shared by the counter, monitor and bench files.
// assumes a core that issues move-to / move-from monitor register strobes.
//
// What this block does
// (RULE_01) four 32-bit counters, overflow raises interrupt
// (RULE_02) each counter counts one of 128 events
// (RULE_03) user alias mirrors each supervisor counter
// (RULE_04) user aliases read-only, user writes change nothing
// (RULE_05) separate supervisor and user register numbers
// (RULE_06) one global control governs all counters
// (RULE_07) user alias mirrors global control
// (RULE_08) event select control picks event, local control
// (RULE_09) threshold control holds threshold and multiplier
// (RULE_10) user aliases mirror both local controls
// (RULE_11) software uses only dedicated monitor moves
// (RULE_12) enabled counter increments, wraps, flags overflow
package epc_pkg;
  localparam int EPC_NUM_CNT = 4;
  localparam int EPC_CNT_W = 32;
  localparam int EPC_NUM_EVT = 128;
  localparam int EPC_SEL_W = 7;
  localparam int EPC_THR_W = 6;
  localparam int EPC_MUL_W = 3;
  localparam int EPC_RUN_W = 16;
  localparam int EPC_NUM_W = 10;

  // ----------------------------------------------------------------
  // register numbers
  // ----------------------------------------------------------------
  localparam logic [9:0] EPC_USR_CNT_BASE = 10'h000;
  localparam logic [9:0] EPC_SUP_CNT_BASE = 10'h010;
  localparam logic [9:0] EPC_USR_SEL_BASE = 10'h080;
  localparam logic [9:0] EPC_SUP_SEL_BASE = 10'h090;
  localparam logic [9:0] EPC_USR_THR_BASE = 10'h100;
  localparam logic [9:0] EPC_SUP_THR_BASE = 10'h110;
  localparam logic [9:0] EPC_USR_GCTL = 10'h180;
  localparam logic [9:0] EPC_SUP_GCTL = 10'h190;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EPC_GCTL_FRZ_ALL = 31;
  localparam int EPC_GCTL_IE = 30;
  localparam int EPC_GCTL_FRZ_OVF = 29;
  localparam int EPC_SEL_FRZ = 31;
  localparam int EPC_SEL_IE = 30;
  localparam int EPC_SEL_LSB = 0;
  localparam int EPC_THR_LSB = 0;
  localparam int EPC_MUL_LSB = 8;

  // ----------------------------------------------------------------
  // implemented bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] EPC_GCTL_MASK = 32'hE000_0000;
  localparam logic [31:0] EPC_SEL_MASK = 32'hC000_007F;
  localparam logic [31:0] EPC_THR_MASK = 32'h0000_073F;
  localparam logic [31:0] EPC_GCTL_RST = 32'h0000_0000;
  localparam logic [31:0] EPC_SEL_RST = 32'h0000_0000;
  localparam logic [31:0] EPC_THR_RST = 32'h0000_0000;
  localparam logic [31:0] EPC_CNT_RST = 32'h0000_0000;
  localparam logic [31:0] EPC_CNT_MAX = 32'hFFFF_FFFF;
endpackage

// ===== include/epc_cnt_if.sv
// interface between the register file and one event counter.
// assumes both ends share the core clock.
`timescale 1ns/1ps
`default_nettype none
interface epc_cnt_if;
  logic [6:0] evt_sel;
  logic [5:0] thr;
  logic [2:0] mult;
  logic freeze;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] count;
  logic ovf;
  modport ctl (output evt_sel, thr, mult, freeze, wr, wdata,
    input count, ovf);
  modport cnt (input evt_sel, thr, mult, freeze, wr, wdata,
    output count, ovf);
endinterface
`default_nettype wire

// ===== design/epc_counter.sv
// one 32-bit event counter with plain and threshold-type events.
// assumes event lines synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module epc_counter
  import epc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [127:0] events_i,
  input wire logic global_freeze_i,
  epc_cnt_if.cnt cif
);
  logic [15:0] run;
  logic [15:0] limit;
  logic sel_line;
  logic thr_type;
  logic hit;
  logic enable;
  logic wrap;

  // ----------------------------------------------------------------
  // event selection
  // ----------------------------------------------------------------
  assign sel_line = events_i[cif.evt_sel]; // [RULE_02]
  // upper half of the event space is threshold-type
  assign thr_type = cif.evt_sel[6];
  assign limit = 16'({10'h000, cif.thr} << cif.mult); // [RULE_09]
  assign hit = thr_type ? (sel_line && run == limit) : sel_line;
  assign enable = !cif.freeze && !global_freeze_i;
  assign wrap = enable && hit && cif.count == EPC_CNT_MAX;

  // run length saturates so a long event counts once only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      run <= 16'h0000;
    else if (!sel_line)
      run <= 16'h0000;
    else if (run != 16'hFFFF)
      run <= 16'(run + 16'h0001);
  end

  // ----------------------------------------------------------------
  // count and overflow
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cif.count <= EPC_CNT_RST;
    else if (cif.wr)
      cif.count <= cif.wdata;
    else if (enable && hit)
      cif.count <= 32'(cif.count + 32'h0000_0001); // [RULE_12]
  end

  // set wins over the clear caused by a counter write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cif.ovf <= 1'b0;
    else
      cif.ovf <= wrap || (cif.ovf && !cif.wr); // [RULE_12]
  end

  a_count_incr: assert property (@(posedge clk_i) // [RULE_12]
    disable iff (rst_i)
    enable && hit && !cif.wr |=>
    cif.count == 32'($past(cif.count) + 32'h0000_0001))
    else $error("counter did not step on its event");
  a_wrap_ovf: assert property (@(posedge clk_i) // [RULE_12]
    disable iff (rst_i)
    wrap && !cif.wr |=> cif.ovf && cif.count == 32'h0000_0000)
    else $error("wrap did not flag overflow");
  a_frozen_hold: assert property (@(posedge clk_i) // [RULE_06]
    disable iff (rst_i)
    (global_freeze_i || cif.freeze) && !cif.wr |=> $stable(cif.count))
    else $error("frozen counter moved");
  a_thr_single: assert property (@(posedge clk_i) // [RULE_09]
    disable iff (rst_i)
    enable && thr_type && sel_line && !cif.wr && run != limit
    |=> $stable(cif.count))
    else $error("threshold event counted off its limit");
endmodule // epc_counter
`default_nettype wire

// ===== design/epc_monitor.sv
// top of the event performance counter block: monitor register file,
// access decode for supervisor and user numbers, four counters.
// assumes one access strobe per cycle from the core's monitor moves.
`timescale 1ns/1ps
`default_nettype none
module epc_monitor
  import epc_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic [127:0] EVENT_I,
  input wire logic MON_WR_I,
  input wire logic MON_RD_I,
  input wire logic MON_USER_I,
  input wire logic [9:0] MON_NUM_I,
  input wire logic [31:0] MON_WDATA_I,
  output logic [31:0] MON_RDATA_O,
  output logic MON_RVALID_O,
  output logic MON_ACC_ERR_O,
  output logic PERF_INT_O
);
  logic [31:0] gctl;
  logic [31:0] lsel [EPC_NUM_CNT];
  logic [31:0] lthr [EPC_NUM_CNT];
  logic [31:0] cnt_val [EPC_NUM_CNT];
  logic [3:0] ovf;
  logic [3:0] cnt_wr;
  logic [3:0] sel_wr;
  logic [3:0] thr_wr;
  logic [3:0] ovf_ie;
  logic sup_wr;
  logic gctl_wr;
  logic global_freeze;
  logic [31:0] next_rdata;
  logic rd_mapped;
  logic wr_mapped;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // user-mode writes never reach any state
  assign sup_wr = MON_WR_I && !MON_USER_I; // [RULE_04]
  assign gctl_wr = sup_wr && MON_NUM_I == EPC_SUP_GCTL; // [RULE_05]

  always_comb
  begin
    cnt_wr = 4'h0;
    sel_wr = 4'h0;
    thr_wr = 4'h0;
    for (int k = 0; k < EPC_NUM_CNT; k++)
    begin
      cnt_wr[k] = sup_wr &&
        MON_NUM_I == 10'(EPC_SUP_CNT_BASE + k); // [RULE_05]
      sel_wr[k] = sup_wr && MON_NUM_I == 10'(EPC_SUP_SEL_BASE + k);
      thr_wr[k] = sup_wr && MON_NUM_I == 10'(EPC_SUP_THR_BASE + k);
    end
  end

  // ----------------------------------------------------------------
  // global control
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      gctl <= EPC_GCTL_RST;
    else if (gctl_wr)
      gctl <= MON_WDATA_I & EPC_GCTL_MASK; // [RULE_06]
  end

  // freeze on overflow stops all counters at once
  assign global_freeze = gctl[EPC_GCTL_FRZ_ALL] ||
    (gctl[EPC_GCTL_FRZ_OVF] && |ovf); // [RULE_06]

  // ----------------------------------------------------------------
  // local controls
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      for (int k = 0; k < EPC_NUM_CNT; k++)
        lsel[k] <= EPC_SEL_RST;
    end
    else
    begin
      for (int k = 0; k < EPC_NUM_CNT; k++)
        if (sel_wr[k])
          lsel[k] <= MON_WDATA_I & EPC_SEL_MASK; // [RULE_08]
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      for (int k = 0; k < EPC_NUM_CNT; k++)
        lthr[k] <= EPC_THR_RST;
    end
    else
    begin
      for (int k = 0; k < EPC_NUM_CNT; k++)
        if (thr_wr[k])
          lthr[k] <= MON_WDATA_I & EPC_THR_MASK; // [RULE_09]
    end
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  for (genvar k = 0; k < EPC_NUM_CNT; k++)
  begin : g_cnt
    epc_cnt_if cif ();
    assign cif.evt_sel = lsel[k][EPC_SEL_LSB +: EPC_SEL_W]; // [RULE_08]
    assign cif.freeze = lsel[k][EPC_SEL_FRZ];
    assign cif.thr = lthr[k][EPC_THR_LSB +: EPC_THR_W];
    assign cif.mult = lthr[k][EPC_MUL_LSB +: EPC_MUL_W];
    assign cif.wr = cnt_wr[k];
    assign cif.wdata = MON_WDATA_I;
    assign cnt_val[k] = cif.count;
    assign ovf[k] = cif.ovf;
    assign ovf_ie[k] = lsel[k][EPC_SEL_IE];

    epc_counter u_cnt (
      .clk_i(REF_CLK_I),
      .rst_i(RESET_I),
      .events_i(EVENT_I),
      .global_freeze_i(global_freeze),
      .cif(cif)
    );

    a_cnt_alias: assert property (@(posedge REF_CLK_I) // [RULE_03]
      disable iff (RESET_I)
      MON_RD_I && MON_NUM_I == 10'(EPC_USR_CNT_BASE + k)
      |=> MON_RVALID_O && MON_RDATA_O == $past(cnt_val[k]))
      else $error("user counter alias differs from counter");
    a_local_alias: assert property (@(posedge REF_CLK_I) // [RULE_10]
      disable iff (RESET_I)
      MON_RD_I && MON_NUM_I == 10'(EPC_USR_SEL_BASE + k)
      |=> MON_RDATA_O == $past(lsel[k]))
      else $error("user event select alias differs");
    a_thr_alias: assert property (@(posedge REF_CLK_I) // [RULE_10]
      disable iff (RESET_I)
      MON_RD_I && MON_NUM_I == 10'(EPC_USR_THR_BASE + k)
      |=> MON_RDATA_O == $past(lthr[k]))
      else $error("user threshold alias differs");
    a_sup_cnt_read: assert property (@(posedge REF_CLK_I) // [RULE_05]
      disable iff (RESET_I)
      MON_RD_I && !MON_USER_I && MON_NUM_I == 10'(EPC_SUP_CNT_BASE + k)
      |=> MON_RDATA_O == $past(cnt_val[k]))
      else $error("supervisor counter read differs");
    a_cnt_write: assert property (@(posedge REF_CLK_I) // [RULE_05]
      disable iff (RESET_I)
      cnt_wr[k] |=> cnt_val[k] == $past(MON_WDATA_I))
      else $error("counter write lost");
    a_sel_write: assert property (@(posedge REF_CLK_I) // [RULE_08]
      disable iff (RESET_I)
      sel_wr[k] |=> lsel[k] == ($past(MON_WDATA_I) & EPC_SEL_MASK))
      else $error("event select write lost");
    a_thr_write: assert property (@(posedge REF_CLK_I) // [RULE_09]
      disable iff (RESET_I)
      thr_wr[k] |=> lthr[k] == ($past(MON_WDATA_I) & EPC_THR_MASK))
      else $error("threshold write lost");
    // a counter write still lands while the others stand frozen
    a_ovf_freeze: assert property (@(posedge REF_CLK_I) // [RULE_06]
      disable iff (RESET_I)
      gctl[EPC_GCTL_FRZ_OVF] && |ovf && !cnt_wr[k]
      |=> $stable(cnt_val[k]))
      else $error("counter moved while frozen on overflow");
  end

  // ----------------------------------------------------------------
  // read decode, supervisor numbers refused in user mode
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    rd_mapped = 1'b0;
    if (MON_NUM_I == EPC_USR_GCTL ||
        (!MON_USER_I && MON_NUM_I == EPC_SUP_GCTL))
    begin
      next_rdata = gctl; // [RULE_07]
      rd_mapped = 1'b1;
    end
    for (int k = 0; k < EPC_NUM_CNT; k++)
    begin
      if (MON_NUM_I == 10'(EPC_USR_CNT_BASE + k) ||
          (!MON_USER_I && MON_NUM_I == 10'(EPC_SUP_CNT_BASE + k)))
      begin
        next_rdata = cnt_val[k]; // [RULE_03]
        rd_mapped = 1'b1;
      end
      if (MON_NUM_I == 10'(EPC_USR_SEL_BASE + k) ||
          (!MON_USER_I && MON_NUM_I == 10'(EPC_SUP_SEL_BASE + k)))
      begin
        next_rdata = lsel[k]; // [RULE_10]
        rd_mapped = 1'b1;
      end
      if (MON_NUM_I == 10'(EPC_USR_THR_BASE + k) ||
          (!MON_USER_I && MON_NUM_I == 10'(EPC_SUP_THR_BASE + k)))
      begin
        next_rdata = lthr[k]; // [RULE_10]
        rd_mapped = 1'b1;
      end
    end
  end

  // any write at a user number or in user mode is refused
  assign wr_mapped = gctl_wr || |cnt_wr || |sel_wr || |thr_wr; // [RULE_04]

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      MON_RDATA_O <= 32'h0000_0000;
    else if (MON_RD_I)
      MON_RDATA_O <= next_rdata; // [RULE_05]
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      MON_RVALID_O <= 1'b0;
    else
      MON_RVALID_O <= MON_RD_I;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      MON_ACC_ERR_O <= 1'b0;
    else
      MON_ACC_ERR_O <= (MON_RD_I && !rd_mapped) ||
        (MON_WR_I && !wr_mapped);
  end

  // ----------------------------------------------------------------
  // overflow interrupt, registered to keep the output glitch free
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      PERF_INT_O <= 1'b0;
    else
      PERF_INT_O <= gctl[EPC_GCTL_IE] && |(ovf & ovf_ie); // [RULE_01]
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_user_wr_blocked: assert property (@(posedge REF_CLK_I) // [RULE_04]
    disable iff (RESET_I)
    MON_WR_I && MON_USER_I |=> $stable(gctl) && $stable(lsel[0]) &&
    $stable(lthr[0]) && MON_ACC_ERR_O)
    else $error("user write changed monitor state");
  a_user_num_wr: assert property (@(posedge REF_CLK_I) // [RULE_04]
    disable iff (RESET_I)
    MON_WR_I && MON_NUM_I == EPC_USR_GCTL
    |=> $stable(gctl) && MON_ACC_ERR_O)
    else $error("write at a user number was taken");
  a_gctl_alias: assert property (@(posedge REF_CLK_I) // [RULE_07]
    disable iff (RESET_I)
    MON_RD_I && MON_NUM_I == EPC_USR_GCTL
    |=> MON_RDATA_O == $past(gctl))
    else $error("user global alias differs");
  a_sup_refused: assert property (@(posedge REF_CLK_I) // [RULE_05]
    disable iff (RESET_I)
    MON_RD_I && MON_USER_I && MON_NUM_I == EPC_SUP_GCTL
    |=> MON_RDATA_O == 32'h0000_0000 && MON_ACC_ERR_O)
    else $error("user mode read a supervisor number");
  a_unmapped_err: assert property (@(posedge REF_CLK_I) // [RULE_05]
    disable iff (RESET_I)
    MON_RD_I && MON_NUM_I[9]
    |=> MON_RDATA_O == 32'h0000_0000 && MON_ACC_ERR_O)
    else $error("unmapped read not refused");
  a_rvalid_pulse: assert property (@(posedge REF_CLK_I) // [RULE_05]
    disable iff (RESET_I)
    MON_RD_I |=> MON_RVALID_O)
    else $error("read without valid");
  a_rvalid_idle: assert property (@(posedge REF_CLK_I) // [RULE_05]
    disable iff (RESET_I)
    !MON_RD_I |=> !MON_RVALID_O)
    else $error("valid without read");
  a_rdata_hold: assert property (@(posedge REF_CLK_I) // [RULE_05]
    disable iff (RESET_I)
    !MON_RD_I |=> $stable(MON_RDATA_O))
    else $error("read data moved without a read");
  a_err_quiet: assert property (@(posedge REF_CLK_I) // [RULE_05]
    disable iff (RESET_I)
    !MON_RD_I && !MON_WR_I |=> !MON_ACC_ERR_O)
    else $error("access error without access");

  // ----------------------------------------------------------------
  // interrupt and global control checks
  // ----------------------------------------------------------------
  a_int_raise: assert property (@(posedge REF_CLK_I) // [RULE_01]
    disable iff (RESET_I)
    gctl[EPC_GCTL_IE] && |(ovf & ovf_ie) |=> PERF_INT_O)
    else $error("overflow did not raise interrupt");
  a_int_drop: assert property (@(posedge REF_CLK_I) // [RULE_01]
    disable iff (RESET_I)
    !(|(ovf & ovf_ie)) |=> !PERF_INT_O)
    else $error("interrupt without enabled overflow");
  a_int_quiet: assert property (@(posedge REF_CLK_I) // [RULE_06]
    disable iff (RESET_I)
    !gctl[EPC_GCTL_IE] |=> !PERF_INT_O)
    else $error("interrupt with global enable off");
  a_gctl_write: assert property (@(posedge REF_CLK_I) // [RULE_06]
    disable iff (RESET_I)
    gctl_wr |=> gctl == ($past(MON_WDATA_I) & EPC_GCTL_MASK))
    else $error("global control write lost");
endmodule // epc_monitor
`default_nettype wire

// ===== tb/event_performance_counters_bench.sv
// self-checking bench for the event performance counter block.
// assumes epc_pkg compiled first; drives all ports at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module event_performance_counters_bench;
  import epc_pkg::*;
  logic ref_clk, reset, mon_wr, mon_rd, mon_user;
  logic [127:0] event_lines;
  logic [9:0] mon_num, n;
  logic [31:0] mon_wdata, mon_rdata, lf;
  logic mon_rvalid, mon_acc_err, perf_int;
  logic [31:0] m_cnt[4], m_sel[4], m_thr[4], m_gctl;
  logic [3:0] m_ovf;
  logic [9:0] sb[4];
  int failures, cmp_count;

  epc_monitor DUT (.REF_CLK_I(ref_clk), .RESET_I(reset),
    .EVENT_I(event_lines), .MON_WR_I(mon_wr), .MON_RD_I(mon_rd),
    .MON_USER_I(mon_user), .MON_NUM_I(mon_num), .MON_WDATA_I(mon_wdata),
    .MON_RDATA_O(mon_rdata), .MON_RVALID_O(mon_rvalid),
    .MON_ACC_ERR_O(mon_acc_err), .PERF_INT_O(perf_int));

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h0020_0003 : 32'h0000_0000);
  endfunction

  function automatic logic intx();
    return m_gctl[30] && |(m_ovf & {m_sel[3][30], m_sel[2][30],
      m_sel[1][30], m_sel[0][30]});
  endfunction

  // decode of the register numbers; n[4] marks the supervisor number
  function automatic logic [31:0] mrd(input logic [9:0] a, input logic u,
    input logic w, output logic e);
    logic ok;
    ok = !a[9] && a[6:5] == 2'h0 && a[3:2] == 2'h0
      && (a[8:7] != 2'h3 || a[1:0] == 2'h0);
    e = !ok || (u && a[4]) || (w && (u || !a[4]));
    case (a[8:7])
      2'h0: mrd = m_cnt[a[1:0]];
      2'h1: mrd = m_sel[a[1:0]];
      2'h2: mrd = m_thr[a[1:0]];
      default: mrd = m_gctl;
    endcase
    if (e)
      mrd = 32'h0000_0000;
  endfunction

  // one monitor move; only dedicated moves reach the registers
  task automatic acc(input logic w, input logic u, input logic [9:0] a,
    input logic [31:0] d);
    logic e;
    logic [31:0] x;
    x = mrd(a, u, w, e);
    @(negedge ref_clk);
    mon_wr <= w;
    mon_rd <= !w;
    mon_user <= u;
    mon_num <= a;
    mon_wdata <= d;
    @(negedge ref_clk);
    mon_wr <= 1'b0;
    mon_rd <= 1'b0;
    check({31'h0, mon_acc_err}, {31'h0, e});
    check({31'h0, mon_rvalid}, {31'h0, !w});
    if (!w)
      check(mon_rdata, x);
    if (w && !e)
      case (a[8:7])
        2'h0:
        begin
          m_cnt[a[1:0]] = d;
          m_ovf[a[1:0]] = 1'b0;
        end
        2'h1: m_sel[a[1:0]] = d & EPC_SEL_MASK;
        2'h2: m_thr[a[1:0]] = d & EPC_THR_MASK;
        default: m_gctl = d & EPC_GCTL_MASK;
      endcase
  endtask

  // one cycle of event lines; plain events only, threshold added by hand
  task automatic cyc(input logic [127:0] ev);
    logic frz;
    // freeze on overflow acts from the cycle after the wrap
    frz = m_gctl[31] || (m_gctl[29] && |m_ovf);
    @(negedge ref_clk);
    event_lines <= ev;
    for (int k = 0; k < 4; k++)
      if (!frz && !m_sel[k][31] && !m_sel[k][6]
        && ev[m_sel[k][6:0]])
      begin
        m_cnt[k]++;
        if (m_cnt[k] == 32'h0000_0000)
          m_ovf[k] = 1'b1;
      end
  endtask

  // a hang is cut short here and counted as a mismatch
  initial
  begin
    #2500000;
    failures++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    {mon_wr, mon_rd, mon_user, mon_num, mon_wdata} = '0;
    event_lines = '0;
    failures = 0;
    cmp_count = 0;
    lf = 32'h53fa;
    m_gctl = EPC_GCTL_RST;
    m_ovf = 4'h0;
    sb = '{EPC_SUP_CNT_BASE, EPC_SUP_SEL_BASE, EPC_SUP_THR_BASE,
      EPC_SUP_GCTL};
    for (int k = 0; k < 4; k++)
      {m_cnt[k], m_sel[k], m_thr[k]} = {EPC_CNT_RST, EPC_SEL_RST,
        EPC_THR_RST};
    repeat (12) @(negedge ref_clk);
    reset <= 1'b0;
    // reset values, then random writes, refused writes, alias reads
    for (int p = 0; p < 2; p++)
      for (int g = 0; g < 4; g++)
        for (int k = 0; k < 4; k++)
          if (g < 3 || k == 0)
          begin
            n = sb[g] + 10'(k);
            if (p == 1)
            begin
              lf = nxt(lf);
              acc(1'b1, 1'b0, n, lf);
              acc(1'b1, 1'b1, n, ~lf);
              acc(1'b1, 1'b0, n & ~10'h010, ~lf);
            end
            acc(1'b0, 1'b0, n, 32'h0);
            acc(1'b0, 1'b1, n, 32'h0);
            acc(1'b0, 1'b1, n & ~10'h010, 32'h0);
            acc(1'b0, 1'b0, n & ~10'h010, 32'h0);
          end
    acc(1'b0, 1'b0, 10'h3FF, 32'h0);
    acc(1'b0, 1'b0, 10'h024, 32'h0);
    acc(1'b0, 1'b0, 10'h191, 32'h0);
    acc(1'b1, 1'b0, 10'h200, lf);
    // plain counting on random event lines, counter 1 near wrap
    acc(1'b1, 1'b0, EPC_SUP_GCTL, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      acc(1'b1, 1'b0, EPC_SUP_SEL_BASE + 10'(k), 32'h4000_0000 | 32'(k * 9));
      acc(1'b1, 1'b0, EPC_SUP_CNT_BASE + 10'(k),
        (k == 1) ? 32'hFFFF_FFFC : 32'h0);
    end
    for (int p = 0; p < 3; p++)
    begin
      if (p == 1)
        acc(1'b1, 1'b0, EPC_SUP_GCTL, 32'h8000_0000);
      if (p == 2)
      begin
        acc(1'b1, 1'b0, EPC_SUP_GCTL, 32'h0);
        acc(1'b1, 1'b0, EPC_SUP_SEL_BASE, 32'h8000_0000);
      end
      for (int c = 0; c < 30; c++)
      begin
        lf = nxt(lf);
        cyc({4{lf}});
      end
      cyc('0);
      for (int k = 0; k < 4; k++)
        acc(1'b0, 1'b0, EPC_SUP_CNT_BASE + 10'(k),
          32'h0);
    end
    check({31'h0, perf_int}, {31'h0, intx()});
    acc(1'b1, 1'b0, EPC_SUP_GCTL, 32'h4000_0000);
    cyc('0);
    check({31'h0, perf_int}, 32'h0000_0001);
    acc(1'b1, 1'b0, EPC_SUP_CNT_BASE + 10'h001, 32'h0000_0005);
    cyc('0);
    check({31'h0, perf_int}, 32'h0000_0000);
    // threshold event 70 with limit 2 << 1: a run of 7 counts once
    acc(1'b1, 1'b0, EPC_SUP_SEL_BASE, 32'h0000_0046);
    acc(1'b1, 1'b0, EPC_SUP_THR_BASE, 32'h0000_0102);
    repeat (7) cyc(128'h1 << 70);
    m_cnt[0]++;
    cyc('0);
    repeat (4) cyc(128'h1 << 70); // run stops one short of the limit
    cyc('0);
    acc(1'b0, 1'b0, EPC_SUP_CNT_BASE, 32'h0);
    // freeze on overflow: counter 1 wraps, every counter stops after
    acc(1'b1, 1'b0, EPC_SUP_CNT_BASE + 10'h001, 32'hFFFF_FFFF);
    acc(1'b1, 1'b0, EPC_SUP_GCTL, 32'h2000_0000);
    repeat (3) cyc('1);
    cyc('0);
    for (int k = 0; k < 4; k++)
      acc(1'b0, 1'b0, EPC_SUP_CNT_BASE + 10'(k), 32'h0);
    check({31'h0, perf_int}, {31'h0, intx()});
    give_verdict();
  end
endmodule // event_performance_counters_bench
`default_nettype wire
